//--- lius_cfg.svh
`ifndef LIUS_CFG_SVH
`define LIUS_CFG_SVH
// Message kinds on the interrupt message link
`define LIUS_KIND_WAKEUP 2'h1
`define LIUS_KIND_RESTART 2'h2
`define LIUS_KIND_FIXED 2'h3
// Timer control field positions
`define LIUS_TMR_PERIODIC_BIT 0
// Reset values
`define LIUS_VECTOR_RESET 8'h00
`define LIUS_COUNT_RESET 32'h0000_0000
`define LIUS_DIV_RESET 8'h01
`endif

//--- lius_core.sv
`timescale 1ns/1ps
`include "lius_cfg.svh"
// Notes on behaviour
// (RULE1) Upgrade role: after reset, halt and wait for wake-up, no reset-vector fetch.
// (RULE2) Restart by pin or message also leads to the halted wait.
// (RULE3) Restart message while halted is held pending until wake-up arrives.
// (RULE4) After wake-up accepted, obey restart messages, discard further wake-ups.
// (RULE5) Wake-up acceptance re-armed only by reset or new restart.
// (RULE6) Primary role ignores every wake-up message entirely.
// (RULE7) Software should shut down only by restart, no wake-ups once running.
// (RULE8) Boot processor sends restart, then waits 10 ms.
// (RULE9) Then two wake-ups, each followed by 200 us, unless older controller.
// (RULE10) Boot processor confirms secondary is running before relying on it.
// (RULE11) Every tick has divisor width except the final one, one timer clock.
// (RULE12) Shortened final tick also happens in single-shot mode.
// (RULE13) Current count loads from initial count one bus clock after write.
// (RULE14) Message failing checksum is resent, not delivered.
// (RULE15) Accepted wake-up starts execution at the vector it carries.
module lius_core #(
   parameter int COUNT_W = 32
) (
   input wire clk_i,
   input wire reset_i,
   input wire link_clk_i,
   input wire link_reset_i,
   input wire upgrade_role_i,
   input wire restart_pin_i,
   input wire msg_valid_i,
   input wire [1:0] msg_kind_i,
   input wire [7:0] msg_vector_i,
   input wire [3:0] msg_sum_i,
   input wire init_count_wr_i,
   input wire [COUNT_W-1:0] init_count_i,
   input wire [7:0] divisor_i,
   input wire periodic_i,
   output logic resend_o,
   output logic halted_o,
   output logic start_o,
   output logic [7:0] start_vector_o,
   output logic restart_pending_o,
   output logic tick_o,
   output logic timer_done_o,
   output logic [COUNT_W-1:0] timer_current_count_o
);
   typedef struct packed {
      logic [1:0] role_sync;
      logic [1:0] pin_sync;
      logic pin_last;
      logic [2:0] tog_sync;
      lius_pkg::lius_cpu_state_t cpu;
      logic wake_armed;
      logic restart_pending;
      logic start;
      logic [7:0] start_vector;
      logic load_pending;
      logic [COUNT_W-1:0] init_count;
      logic [COUNT_W-1:0] current_count;
      logic [7:0] div_cnt;
      logic tick;
      logic done;
      logic running;
      logic boot_done;
      logic [1:0] settle;
   } lius_core_state_t;

   lius_core_state_t state_reg;
   lius_core_state_t state_next;

   logic rx_resend;
   logic [1:0] rx_kind;
   logic [7:0] rx_vector;
   logic rx_toggle;

   lius_link_rx u_rx (
      .link_clk_i(link_clk_i),
      .link_reset_i(link_reset_i),
      .msg_valid_i(msg_valid_i),
      .msg_kind_i(msg_kind_i),
      .msg_vector_i(msg_vector_i),
      .msg_sum_i(msg_sum_i),
      .resend_o(rx_resend),
      .kind_o(rx_kind),
      .vector_o(rx_vector),
      .toggle_o(rx_toggle)
   );

   // Resend request goes straight back onto the link in its own domain
   assign resend_o = rx_resend;

   logic msg_evt;
   logic is_wake;
   logic is_restart;
   logic pin_rise;
   logic upgrade;

   always_comb begin
      state_next = state_reg;
      state_next.role_sync = {state_reg.role_sync[0], upgrade_role_i};
      state_next.pin_sync = {state_reg.pin_sync[0], restart_pin_i};
      state_next.pin_last = state_reg.pin_sync[1];
      state_next.tog_sync = {state_reg.tog_sync[1:0], rx_toggle};
      state_next.settle = {state_reg.settle[0], 1'b1};
      state_next.start = 1'b0;
      state_next.tick = 1'b0;
      state_next.done = 1'b0;
      upgrade = state_reg.role_sync[1];
      pin_rise = state_reg.pin_sync[1] & ~state_reg.pin_last;
      // Word was stable before the toggle, so it is safe to read here
      msg_evt = state_reg.tog_sync[2] ^ state_reg.tog_sync[1];
      is_wake = msg_evt && (rx_kind == `LIUS_KIND_WAKEUP);
      is_restart = msg_evt && (rx_kind == `LIUS_KIND_RESTART);

      // Startup sequencing
      if (!state_reg.settle[1]) begin
         // Role not synchronised yet: a zero here must not pass for the primary role
         state_next.cpu = state_reg.cpu; // RULE1
      end else if (upgrade) begin
         if (pin_rise) begin
            state_next.cpu = lius_pkg::LIUS_HALT_WAIT; // RULE2
            state_next.wake_armed = 1'b1; // RULE5
            state_next.restart_pending = 1'b0;
         end else if (state_reg.cpu == lius_pkg::LIUS_HALT_WAIT) begin
            if (is_restart) begin
               state_next.restart_pending = 1'b1; // RULE3
            end else if (is_wake && state_reg.wake_armed) begin
               state_next.wake_armed = 1'b0; // RULE4
               if (state_reg.restart_pending) begin
                  // Held restart acts now: back to halted wait, re-armed
                  state_next.restart_pending = 1'b0; // RULE3
                  state_next.wake_armed = 1'b1; // RULE5
               end else begin
                  state_next.cpu = lius_pkg::LIUS_RUN;
                  state_next.start = 1'b1; // RULE15
                  state_next.start_vector = rx_vector; // RULE15
               end
            end
         end else begin
            case (state_reg.cpu)
               lius_pkg::LIUS_RUN: begin
                  if (is_restart) begin
                     state_next.cpu = lius_pkg::LIUS_HALT_WAIT; // RULE2 RULE4
                     state_next.wake_armed = 1'b1; // RULE5
                  end
                  // Wake-ups while running fall through unused
               end
               default: begin
                  state_next.cpu = lius_pkg::LIUS_HALT_WAIT;
               end
            endcase
         end
      end else begin
         // Primary role: restarts restart at reset vector, wake-ups do nothing
         state_next.cpu = lius_pkg::LIUS_RUN; // RULE6
         state_next.wake_armed = 1'b0;
         state_next.restart_pending = 1'b0;
         if (!state_reg.boot_done || pin_rise || is_restart) begin
            state_next.start = 1'b1;
            state_next.start_vector = `LIUS_VECTOR_RESET;
         end
      end
      state_next.boot_done = state_reg.boot_done | state_reg.settle[1];

      // Timer
      state_next.load_pending = init_count_wr_i;
      if (init_count_wr_i) begin
         state_next.init_count = init_count_i;
      end
      if (state_reg.load_pending) begin
         state_next.current_count = state_reg.init_count; // RULE13
         state_next.div_cnt = 8'h00;
         state_next.running = (state_reg.init_count != '0);
      end else if (state_reg.running) begin
         if (state_reg.current_count == COUNT_W'(1)) begin
            // Final tick lasts one timer clock, whatever the divisor
            state_next.tick = 1'b1; // RULE11
            state_next.done = 1'b1;
            state_next.div_cnt = 8'h00;
            if (periodic_i) begin
               state_next.current_count = state_reg.init_count;
            end else begin
               state_next.current_count = '0; // RULE12
               state_next.running = 1'b0;
            end
         end else begin
            state_next.tick = 1'b1; // RULE11
            if (state_reg.div_cnt + 8'h01 >= divisor_i) begin
               state_next.div_cnt = 8'h00;
               state_next.current_count = state_reg.current_count - COUNT_W'(1);
            end else begin
               state_next.div_cnt = state_reg.div_cnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= '0;
         // Upgrade role never fetches the reset vector on its own
         state_reg.cpu <= lius_pkg::LIUS_HALT_WAIT; // RULE1
         state_reg.wake_armed <= 1'b1; // RULE5
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         halted_o <= 1'b0;
      end else begin
         halted_o <= (state_next.cpu == lius_pkg::LIUS_HALT_WAIT) && state_reg.role_sync[1];
      end
   end

   assign start_o = state_reg.start;
   assign start_vector_o = state_reg.start_vector;
   assign restart_pending_o = state_reg.restart_pending;
   assign tick_o = state_reg.tick;
   assign timer_done_o = state_reg.done;
   assign timer_current_count_o = state_reg.current_count;
endmodule

//--- lius_link_rx.sv
`timescale 1ns/1ps
`include "lius_cfg.svh"
// Link-clock side: receives messages, checks sum, requests resend on error
module lius_link_rx (
   input wire link_clk_i,
   input wire link_reset_i,
   input wire msg_valid_i,
   input wire [1:0] msg_kind_i,
   input wire [7:0] msg_vector_i,
   input wire [3:0] msg_sum_i,
   output logic resend_o,
   output logic [1:0] kind_o,
   output logic [7:0] vector_o,
   output logic toggle_o
);
   typedef struct packed {
      logic resend;
      logic [1:0] kind;
      logic [7:0] vector;
      logic toggle;
   } lius_rx_state_t;

   lius_rx_state_t state_reg;
   lius_rx_state_t state_next;

   function automatic logic [3:0] lius_sum(input logic [1:0] k, input logic [7:0] v);
      lius_sum = {2'h0, k} + v[3:0] + v[7:4];
   endfunction

   always_comb begin
      state_next = state_reg;
      state_next.resend = 1'b0;
      if (msg_valid_i) begin
         if (lius_sum(msg_kind_i, msg_vector_i) != msg_sum_i) begin
            // Bad message is never handed on
            state_next.resend = 1'b1; // RULE14
         end else begin
            state_next.kind = msg_kind_i;
            state_next.vector = msg_vector_i;
            state_next.toggle = ~state_reg.toggle;
         end
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign resend_o = state_reg.resend;
   assign kind_o = state_reg.kind;
   assign vector_o = state_reg.vector;
   assign toggle_o = state_reg.toggle;
endmodule

//--- lius_partner.sv
`timescale 1ns/1ps
module lius_partner (
   input wire link_clk_i,
   output logic msg_valid_o,
   output logic [1:0] msg_kind_o,
   output logic [7:0] msg_vector_o,
   output logic [3:0] msg_sum_o
);
   initial begin
      msg_valid_o = 1'b0;
      msg_kind_o = 2'h0;
      msg_vector_o = 8'h00;
      msg_sum_o = 4'h0;
   end
   task automatic send(input logic [1:0] k, input logic [7:0] v, input logic bad);
      @(negedge link_clk_i);
      msg_valid_o = 1'b1;
      msg_kind_o = k;
      msg_vector_o = v;
      msg_sum_o = 4'(k + v[3:0] + v[7:4]) ^ {3'h0, bad};
      @(negedge link_clk_i);
      msg_valid_o = 1'b0;
      // Idle vector and sum inverted so stale values never pass for a message
      msg_vector_o = ~v;
      msg_sum_o = ~msg_sum_o;
      repeat (2) @(negedge link_clk_i);
   endtask
endmodule

//--- lius_pkg.sv
package lius_pkg;
   typedef enum {
      LIUS_RUN,
      LIUS_HALT_WAIT
   } lius_cpu_state_t;
endpackage

//--- lius_props.sv
`timescale 1ns/1ps
module lius_props #(
   parameter int COUNT_W = 32
) (
   input wire clk_i,
   input wire reset_i,
   input wire link_clk_i,
   input wire link_reset_i,
   input wire upgrade_role_i,
   input wire init_count_wr_i,
   input wire [COUNT_W-1:0] init_count_i,
   input wire resend_o,
   input wire halted_o,
   input wire start_o,
   input wire restart_pending_o,
   input wire timer_done_o,
   input wire [COUNT_W-1:0] timer_current_count_o
);
   sequence s_boot;
      $fell(reset_i) && upgrade_role_i;
   endsequence
   sequence s_load;
      init_count_wr_i ##3 1'b1;
   endsequence
   a_boot_halts: assert property (@(posedge clk_i) disable iff (reset_i)
      s_boot |-> ##[1:4] halted_o) else $error("no halt after reset");
   a_pend_halted: assert property (@(posedge clk_i) disable iff (reset_i)
      restart_pending_o |-> halted_o) else $error("pending while running");
   a_halt_exit: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(halted_o) |-> start_o || $past(start_o)) else $error("left halt without start");
   a_start_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
      start_o |=> !start_o) else $error("start too long");
   a_primary_run: assert property (@(posedge clk_i) disable iff (reset_i)
      !upgrade_role_i && !$past(upgrade_role_i, 4) |-> !halted_o) else $error("primary halted");
   a_count_load: assert property (@(posedge clk_i) disable iff (reset_i)
      s_load |-> timer_current_count_o == $past(init_count_i, 3)) else $error("bad load");
   a_done_short: assert property (@(posedge clk_i) disable iff (reset_i)
      timer_done_o |=> !timer_done_o) else $error("final tick too long");
   a_resend_one: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      resend_o |=> !resend_o) else $error("resend too long");
endmodule
bind lius_core lius_props #(.COUNT_W(COUNT_W)) lius_props_i (.clk_i(clk_i), .reset_i(reset_i),
   .link_clk_i(link_clk_i), .link_reset_i(link_reset_i), .upgrade_role_i(upgrade_role_i),
   .init_count_wr_i(init_count_wr_i), .init_count_i(init_count_i), .resend_o(resend_o),
   .halted_o(halted_o), .start_o(start_o), .restart_pending_o(restart_pending_o),
   .timer_done_o(timer_done_o), .timer_current_count_o(timer_current_count_o));

//--- testbench.sv
`timescale 1ns/1ps
`include "lius_cfg.svh"
module testbench;
   logic clk_i = 0, link_clk = 0, reset_i = 1, link_reset = 1, role = 1, pin = 0, wr = 0, per = 0;
   logic [31:0] icnt = 32'h0, ccnt;
   logic [7:0] div = 8'h01, svec, m_vec = 8'h00, last_vec = 8'h00;
   logic mv, resend, halted, start, pend, tick, done;
   logic [1:0] mk;
   logic [7:0] mvec;
   logic [3:0] ms;
   int failures = 0, cmp_count = 0, cyc = 0, n_start = 0, n_resend = 0, n_done = 0;
   int m_halt, m_arm, m_pend, m_start = 0, m_resend = 0, n_tick = 0;
   initial forever #12.5 clk_i = ~clk_i;
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end
   lius_core lius_core_i (.clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
      .link_reset_i(link_reset), .upgrade_role_i(role), .restart_pin_i(pin), .msg_valid_i(mv),
      .msg_kind_i(mk), .msg_vector_i(mvec), .msg_sum_i(ms), .init_count_wr_i(wr),
      .init_count_i(icnt), .divisor_i(div), .periodic_i(per), .resend_o(resend),
      .halted_o(halted), .start_o(start), .start_vector_o(svec), .restart_pending_o(pend),
      .tick_o(tick), .timer_done_o(done), .timer_current_count_o(ccnt));
   lius_partner lius_partner_i (.link_clk_i(link_clk), .msg_valid_o(mv), .msg_kind_o(mk),
      .msg_vector_o(mvec), .msg_sum_o(ms));
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (start === 1'b1) begin
         n_start <= n_start + 1;
         last_vec <= svec;
      end
      if (done === 1'b1) n_done <= n_done + 1;
      if (tick === 1'b1) n_tick <= n_tick + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         stop_test;
      end
   end
   always @(posedge link_clk) if (resend === 1'b1) n_resend <= n_resend + 1;
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk_all;
      chk("halted", halted, 32'(m_halt));
      chk("pending", pend, 32'(m_pend));
      chk("starts", 32'(n_start), 32'(m_start));
      chk("vector", last_vec, m_vec);
      chk("resends", 32'(n_resend), 32'(m_resend));
   endtask
   task automatic do_reset(input logic r);
      reset_i = 1'b1;
      link_reset = 1'b1;
      role = r;
      repeat (2) @(posedge link_clk);
      repeat (4) @(negedge clk_i);
      reset_i = 1'b0;
      link_reset = 1'b0;
      m_halt = r;
      m_arm = r;
      m_pend = 0;
      if (!r) begin
         m_start++;
         m_vec = 8'h00;
      end
      repeat (8) @(negedge clk_i);
      chk_all;
   endtask
   task automatic msg(input logic [1:0] k, input logic [7:0] v, input logic bad);
      lius_partner_i.send(k, v, bad);
      repeat (6) @(negedge clk_i);
      if (bad) m_resend++;
      else if (k == `LIUS_KIND_RESTART) begin
         if (m_halt) m_pend = 1;
         m_halt = 1;
         m_arm = 1;
      end else if (k == `LIUS_KIND_WAKEUP && role && m_arm) begin
         // Pending restart wins: stays halted, still armed
         if (m_pend) m_pend = 0;
         else begin
            m_halt = 0;
            m_arm = 0;
            m_start++;
            m_vec = v;
         end
      end
      chk_all;
   endtask
   task automatic tmr(input logic p);
      int n, d, t, d0, t0;
      n = $urandom_range(9, 2);
      d = $urandom_range(4, 1);
      @(negedge clk_i);
      t0 = n_tick;
      per = p;
      div = 8'(d);
      icnt = 32'(n);
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      icnt = $urandom;
      repeat (2) @(negedge clk_i);
      chk("count load", ccnt, 32'(n));
      d0 = n_done;
      t = 0;
      while (n_done < d0 + 2 && t < 200) begin
         @(negedge clk_i);
         t++;
      end
      chk("dones", 32'(n_done), 32'(d0 + (p ? 2 : 1)));
      if (!p) chk("count end", ccnt, 32'h0);
      if (!p) chk("ticks", 32'(n_tick - t0), 32'((n - 1) * d + 1));
   endtask
   initial begin
      void'($urandom(32'h75f4));
      do_reset(1'b1);
      // Boot waits scaled down to keep the run short
      msg(`LIUS_KIND_RESTART, 8'h00, 1'b0);
      repeat (400) @(negedge clk_i);
      msg(`LIUS_KIND_WAKEUP, 8'($urandom), 1'b0);
      repeat (80) @(negedge clk_i);
      msg(`LIUS_KIND_WAKEUP, 8'($urandom), 1'b0);
      msg(`LIUS_KIND_WAKEUP, 8'h5a, 1'b0);
      msg(`LIUS_KIND_RESTART, 8'h00, 1'b0);
      msg(`LIUS_KIND_WAKEUP, 8'hff, 1'b1);
      msg(`LIUS_KIND_WAKEUP, 8'h00, 1'b0);
      @(negedge clk_i);
      pin = 1'b1;
      repeat (8) @(negedge clk_i);
      pin = 1'b0;
      m_halt = 1;
      m_arm = 1;
      repeat (4) @(negedge clk_i);
      chk_all;
      msg(`LIUS_KIND_FIXED, 8'h3c, 1'b0);
      msg(`LIUS_KIND_WAKEUP, 8'h81, 1'b0);
      tmr(1'b0);
      tmr(1'b1);
      do_reset(1'b0);
      msg(`LIUS_KIND_WAKEUP, 8'h42, 1'b0);
      stop_test;
   end
endmodule
